// ===== logic/awr_fifo.sv
// Receive FIFO of 32 words with overwrite of the last location
`timescale 1ns/100ps
`default_nettype none
module awr_fifo (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic clear,
  awr_fifo_if.fifo f
);
  logic [31:0] mem [0:awr_pkg::FIFO_DEPTH-1];
  logic [awr_pkg::PTR_W-1:0] rd_ptr_ff;
  logic [awr_pkg::PTR_W-1:0] wr_ptr_ff;
  logic [awr_pkg::CNT_W-1:0] count_ff;
  logic [awr_pkg::CNT_W-1:0] nxt_count;
  logic [awr_pkg::PTR_W-1:0] wr_slot;
  wire do_rd = f.rd && (count_ff != '0);
  wire is_full = (count_ff == awr_pkg::CNT_W'(awr_pkg::FIFO_DEPTH));
  wire push = f.wr && !(is_full && do_rd);
  // Overwrite of location 32 when full
  assign wr_slot = is_full ? (wr_ptr_ff - 5'h01) : wr_ptr_ff;
  assign nxt_count = count_ff + CNT_W_ONE(push && !is_full) - CNT_W_ONE(do_rd);
  function automatic logic [awr_pkg::CNT_W-1:0] CNT_W_ONE(input logic b);
    CNT_W_ONE = {{(awr_pkg::CNT_W-1){1'b0}}, b};
  endfunction
  assign f.empty = (count_ff == '0);
  assign f.full = is_full;
  assign f.half = (count_ff >= awr_pkg::HALF_COUNT);
  // Oldest word, zero when empty
  assign f.rdata = (count_ff == '0) ? 32'h00000000 : mem[rd_ptr_ff];
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wr_slot] <= f.wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff <= '0;
    end else if (clk_en) begin
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 5'h01;
      end
      if (push && !is_full) begin
        wr_ptr_ff <= wr_ptr_ff + 5'h01;
      end
      count_ff <= nxt_count;
    end
  end
endmodule
`default_nettype wire

// ===== logic/awr_fifo_if.sv
// Interface carrying writes and reads between the receiver and its FIFO
`timescale 1ns/100ps
`default_nettype none
interface awr_fifo_if;
  logic wr;
  logic [31:0] wdata;
  logic rd;
  logic [31:0] rdata;
  logic empty;
  logic full;
  logic half;
  modport fifo (input wr, input wdata, input rd, output rdata, output empty, output full, output half);
  modport user (output wr, output wdata, output rd, input rdata, input empty, input full, input half);
endinterface
`default_nettype wire

// ===== logic/awr_pkg.sv
// Package holding the constants and types of the ARINC word receiver
// What this block does
// - Host word bit 1 is ARINC 32, bits 2-22 are ARINC 31-11, 23 is 10, 24 is 9.
// - Host bits 25-32 carry the label, ascending or reversed by label order select.
// - Three 10-bit sample registers for One, Zero, Null; one high per sample at most.
// - Data bit needs three highs in One/Zero upper half and Null lower half.
// - Word-gap Null needs three highs in both Null register halves.
// - Accepted bits are 8 to 12 samples apart, else reception is rejected.
// - Gap timer checks Null every 10 clocks (80 low speed), counting Nulls.
// - No new word reception starts before the gap counter reaches 3.
// - After 32 valid bits an end-of-word strobe starts filtering and FIFO write.
// - Word stored only if label and bit 10/9 filters are off or pass.
// - A FIFO write sets data ready and clears empty until the FIFO drains.
// - Read opcode 08 hex returns the oldest word and removes it.
// - FIFO holds 32 words, flags full, and overwrites location 32 when full; a write in the same cycle as a read of a full FIFO is dropped.
// - Half-full flag is high while the FIFO holds 16 or more words.
// - Parity check off stores the received 32nd bit unchanged.
// - Parity check on stores 0 for odd parity, 1 for even parity.
// - A 256-bit label table, 1 accepts, written by opcodes 02, 03 or 06 hex.
// - A word dropped by label filtering changes no FIFO flag or data ready, but still pulses the end-of-word strobe.
// - Read opcode 0D hex returns the whole label table.
// - Master clear stops reception, empties FIFO, clears flags, keeps control bits.
package awr_pkg;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] HALF_COUNT = 6'h10;
  localparam int SAMPLE_W = 10;
  localparam int RUN_LEN = 3;
  localparam int REF_MHZ = 1;
  localparam int SYS_MHZ = 40;
  localparam logic [5:0] REF_DIV = 6'(SYS_MHZ / REF_MHZ);
  localparam logic [3:0] BIT_MIN_SAMPLES = 4'h8;
  localparam logic [3:0] BIT_MAX_SAMPLES = 4'hC;
  localparam logic [6:0] GAP_HS_CLOCKS = 7'h0A;
  localparam logic [6:0] GAP_LS_CLOCKS = 7'h50;
  localparam logic [1:0] GAP_NEED = 2'h3;
  localparam logic [7:0] OP_READ_WORD = 8'h08;
  localparam logic [7:0] OP_READ_LABELS = 8'h0D;
  localparam logic [7:0] OP_LABEL_ALL = 8'h02;
  localparam logic [7:0] OP_LABEL_NONE = 8'h03;
  localparam logic [7:0] OP_LABEL_WRITE = 8'h06;
  localparam logic [1:0] LVL_NULL = 2'h0;
  localparam logic [1:0] LVL_ONE = 2'h1;
  localparam logic [1:0] LVL_ZERO = 2'h2;
  localparam logic [1:0] LVL_BETWEEN = 2'h3;
  typedef enum logic [1:0] {AWR_GAP, AWR_DATA, AWR_STROBE} awr_state_t;
endpackage

// ===== logic/awr_receiver.sv
// Top of the ARINC word receiver: sampling, validation, filtering, host access
`timescale 1ns/100ps
`default_nettype none
module awr_receiver (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic master_clear_pin,
  input wire logic [1:0] line_level,
  input wire logic low_speed,
  input wire logic label_order_select,
  input wire logic label_filter_enable,
  input wire logic decode_match_enable,
  input wire logic match_value_bit10,
  input wire logic match_value_bit9,
  input wire logic rx_parity_check_enable,
  input wire logic rx_flag_select_full,
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_opcode,
  input wire logic [255:0] host_label_data,
  output logic host_rsp_valid,
  output logic [31:0] host_word,
  output logic [255:0] host_label_table,
  output logic end_of_word_strobe,
  output logic data_ready,
  output logic rx_fifo_empty_flag,
  output logic rx_fifo_half_flag,
  output logic rx_fifo_full_flag,
  output logic rx_flag_pin
);
  // ------------------------------------------------------------
  // Reference clock tick
  // ------------------------------------------------------------
  logic [5:0] div_ff;
  logic [6:0] gap_clk_ff;
  logic [9:0] one_sr_ff;
  logic [9:0] zero_sr_ff;
  logic [9:0] null_sr_ff;
  logic [3:0] since_ff;
  logic bit_armed_ff;
  logic [5:0] nbits_ff;
  logic [31:0] shift_ff;
  logic [1:0] gap_cnt_ff;
  logic [255:0] label_tab_ff;
  logic rsp_valid_ff;
  logic [31:0] rsp_word_ff;
  logic ready_ff;
  logic eow_ff;
  awr_pkg::awr_state_t state_ff;
  awr_pkg::awr_state_t nxt_state;
  wire clear = !rst_n || master_clear_pin;
  wire tick = clk_en && (div_ff == awr_pkg::REF_DIV - 6'h01);
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      div_ff <= '0;
    end else if (clk_en) begin
      div_ff <= tick ? 6'h00 : div_ff + 6'h01;
    end
  end
  // ------------------------------------------------------------
  // Sampling shift registers
  // ------------------------------------------------------------
  wire is_one = (line_level == awr_pkg::LVL_ONE);
  wire is_zero = (line_level == awr_pkg::LVL_ZERO);
  wire is_null = (line_level == awr_pkg::LVL_NULL);
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      one_sr_ff <= '0;
      zero_sr_ff <= '0;
      null_sr_ff <= '0;
    end else if (tick) begin
      one_sr_ff <= {one_sr_ff[8:0], is_one};
      zero_sr_ff <= {zero_sr_ff[8:0], is_zero};
      null_sr_ff <= {null_sr_ff[8:0], is_null};
    end
  end
  // ------------------------------------------------------------
  // Run detection in register halves (upper is older)
  // ------------------------------------------------------------
  function automatic logic run3(input logic [4:0] h);
    logic r;
    r = 1'b0;
    for (int i = 0; i <= 2; i++) begin
      r = r | (&h[i +: awr_pkg::RUN_LEN]);
    end
    run3 = r;
  endfunction
  wire one_up = run3(one_sr_ff[9:5]);
  wire zero_up = run3(zero_sr_ff[9:5]);
  wire null_up = run3(null_sr_ff[9:5]);
  wire null_lo = run3(null_sr_ff[4:0]);
  wire bit_seen = (one_up || zero_up) && null_lo;
  wire bit_value = one_up;
  wire gap_null = null_up && null_lo;
  wire bit_evt = tick && bit_armed_ff && bit_seen;
  wire rate_ok = (since_ff >= awr_pkg::BIT_MIN_SAMPLES) && (since_ff <= awr_pkg::BIT_MAX_SAMPLES);
  wire first_bit = (nbits_ff == 6'h00);
  wire rate_bad = tick && !first_bit && (since_ff > awr_pkg::BIT_MAX_SAMPLES);
  wire bit_bad = bit_evt && !first_bit && !rate_ok;
  wire in_between = tick && (line_level == awr_pkg::LVL_BETWEEN) && !bit_armed_ff;
  // ------------------------------------------------------------
  // Word gap timer
  // ------------------------------------------------------------
  wire [6:0] gap_period = low_speed ? awr_pkg::GAP_LS_CLOCKS : awr_pkg::GAP_HS_CLOCKS;
  wire gap_tick = tick && (gap_clk_ff == gap_period - 7'h01);
  wire gap_done = (gap_cnt_ff == awr_pkg::GAP_NEED);
  always_ff @(posedge sys_clk) begin
    if (clear || state_ff != awr_pkg::AWR_GAP) begin
      gap_clk_ff <= '0;
      gap_cnt_ff <= '0;
    end else if (gap_tick) begin
      gap_clk_ff <= '0;
      if (!null_sr_ff[0]) begin
        gap_cnt_ff <= 2'h0;
      end else if (!gap_done) begin
        gap_cnt_ff <= gap_cnt_ff + 2'h1;
      end
    end else if (tick) begin
      gap_clk_ff <= gap_clk_ff + 7'h01;
    end
  end
  // ------------------------------------------------------------
  // Reception state machine
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      awr_pkg::AWR_GAP: begin
        if (gap_done && gap_null) begin
          nxt_state = awr_pkg::AWR_DATA;
        end
      end
      awr_pkg::AWR_DATA: begin
        if (bit_bad || rate_bad || in_between) begin
          nxt_state = awr_pkg::AWR_GAP;
        end else if (bit_evt && nbits_ff == 6'h1F) begin
          nxt_state = awr_pkg::AWR_STROBE;
        end
      end
      awr_pkg::AWR_STROBE: begin
        nxt_state = awr_pkg::AWR_GAP;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      state_ff <= awr_pkg::AWR_GAP;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end
  // ------------------------------------------------------------
  // Bit collection; ARINC bit 1 arrives first
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clear || (clk_en && state_ff != awr_pkg::AWR_DATA)) begin
      nbits_ff <= '0;
      since_ff <= '0;
      bit_armed_ff <= 1'b1;
      shift_ff <= '0;
    end else if (bit_evt && (first_bit || rate_ok)) begin
      shift_ff <= {bit_value, shift_ff[31:1]};
      nbits_ff <= nbits_ff + 6'h01;
      since_ff <= 4'h1;
      bit_armed_ff <= 1'b0;
    end else if (tick) begin
      if (!first_bit && since_ff != 4'hF) begin
        since_ff <= since_ff + 4'h1;
      end
      // Re-arm only once the accepted bit pattern is no longer seen in the sample window
      if (!bit_seen) begin
        bit_armed_ff <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // Filtering, parity and host word mapping
  // ------------------------------------------------------------
  wire [7:0] label_raw = shift_ff[7:0];
  wire label_ok = !label_filter_enable || label_tab_ff[label_raw];
  wire match_ok = !decode_match_enable ||
    (shift_ff[9] == match_value_bit10 && shift_ff[8] == match_value_bit9);
  wire eow = (state_ff == awr_pkg::AWR_STROBE) && clk_en;
  wire store = eow && label_ok && match_ok;
  wire par_bit = rx_parity_check_enable ? ~(^shift_ff) : shift_ff[31];
  logic [31:0] host_map;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_label
      assign host_map[7 - gi] = label_order_select ? shift_ff[7 - gi] : shift_ff[gi];
    end
  endgenerate
  assign host_map[31] = par_bit;
  assign host_map[30:10] = shift_ff[30:10];
  assign host_map[9:8] = shift_ff[9:8];
  // ------------------------------------------------------------
  // FIFO and host commands
  // ------------------------------------------------------------
  awr_fifo_if fif ();
  wire rd_cmd = clk_en && host_cmd_valid && (host_opcode == awr_pkg::OP_READ_WORD);
  assign fif.wr = store;
  assign fif.wdata = host_map;
  assign fif.rd = rd_cmd;
  awr_fifo u_fifo (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .clear(clear),
    .f(fif)
  );
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      label_tab_ff <= '0;
    end else if (clk_en && host_cmd_valid) begin
      if (host_opcode == awr_pkg::OP_LABEL_ALL) begin
        label_tab_ff <= {256{1'b1}};
      end else if (host_opcode == awr_pkg::OP_LABEL_NONE) begin
        label_tab_ff <= '0;
      end else if (host_opcode == awr_pkg::OP_LABEL_WRITE) begin
        label_tab_ff <= host_label_data;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      rsp_valid_ff <= 1'b0;
      rsp_word_ff <= '0;
      ready_ff <= 1'b0;
      eow_ff <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_ff <= host_cmd_valid &&
        (host_opcode == awr_pkg::OP_READ_WORD || host_opcode == awr_pkg::OP_READ_LABELS);
      if (rd_cmd) begin
        rsp_word_ff <= fif.rdata;
      end
      eow_ff <= eow;
      if (store) begin
        ready_ff <= 1'b1;
      end else if (fif.empty) begin
        ready_ff <= 1'b0;
      end
    end
  end
  assign host_rsp_valid = rsp_valid_ff;
  assign host_word = rsp_word_ff;
  assign host_label_table = label_tab_ff;
  assign end_of_word_strobe = eow_ff;
  assign data_ready = ready_ff;
  assign rx_fifo_empty_flag = fif.empty;
  assign rx_fifo_half_flag = fif.half;
  assign rx_fifo_full_flag = fif.full;
  assign rx_flag_pin = rx_flag_select_full ? fif.full : fif.empty;
endmodule
`default_nettype wire

// ===== verif/awr_line_model.sv
// Remote word transmitter driving Null, One and Zero line levels
`timescale 1ns/100ps
`default_nettype none
module awr_line_model (
  input wire logic sys_clk,
  output logic [1:0] line_level
);
  initial line_level = awr_pkg::LVL_NULL;
  // Holds one level for a number of 1 MHz ticks
  task automatic hold(input logic [1:0] lvl, input int ticks);
    line_level = lvl;
    repeat (ticks * 40) @(negedge sys_clk);
  endtask
  // Leading gap, then bits one per span ticks, then a trailing Null
  task automatic send_word(input logic [31:0] w, input int span, input int nbits);
    hold(awr_pkg::LVL_NULL, 40);
    for (int i = 0; i < nbits; i++) begin
      hold(w[i] ? awr_pkg::LVL_ONE : awr_pkg::LVL_ZERO, 5);
      hold(awr_pkg::LVL_NULL, span - 5);
    end
    hold(awr_pkg::LVL_NULL, 20);
  endtask
endmodule
`default_nettype wire

// ===== verif/awr_rx_checker.sv
// Port assertions of the ARINC word receiver
`timescale 1ns/100ps
`default_nettype none
module awr_rx_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic master_clear_pin,
  input wire logic rx_flag_select_full,
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_opcode,
  input wire logic host_rsp_valid,
  input wire logic [31:0] host_word,
  input wire logic end_of_word_strobe,
  input wire logic data_ready,
  input wire logic rx_fifo_empty_flag,
  input wire logic rx_fifo_half_flag,
  input wire logic rx_fifo_full_flag,
  input wire logic rx_flag_pin
);
  logic [2:0] eow_hist_ff;
  logic [2:0] nxt_eow_hist;
  assign nxt_eow_hist = {eow_hist_ff[1:0], end_of_word_strobe};
  always_ff @(posedge sys_clk) begin
    eow_hist_ff <= rst_n ? nxt_eow_hist : 3'h0;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_read;
    clk_en && host_cmd_valid && host_opcode == awr_pkg::OP_READ_WORD;
  endsequence
  sequence s_dump;
    clk_en && host_cmd_valid && host_opcode == awr_pkg::OP_READ_LABELS;
  endsequence
  a_rsp_follows: assert property ((s_read or s_dump) |=> host_rsp_valid)
    else $error("read command got no response");
  a_rsp_cause: assert property (host_rsp_valid |-> $past(host_cmd_valid && clk_en))
    else $error("response without a command");
  a_empty_zero: assert property (s_read ##0 rx_fifo_empty_flag |=> host_word == 32'h0)
    else $error("read of empty store not zero");
  a_word_holds: assert property
    (!(host_cmd_valid && host_opcode == awr_pkg::OP_READ_WORD) && !master_clear_pin |=> $stable(host_word))
    else $error("host word changed without a read");
  a_eow_pulse: assert property (end_of_word_strobe |=> !end_of_word_strobe [*8])
    else $error("end of word strobe too long");
  a_store_eow: assert property ($fell(rx_fifo_empty_flag) |-> end_of_word_strobe || (|eow_hist_ff))
    else $error("store without end of word");
  a_store_ready: assert property ($fell(rx_fifo_empty_flag) |-> ##[0:1] data_ready)
    else $error("store did not set data ready");
  a_drain_ready: assert property (rx_fifo_empty_flag [*3] |-> !data_ready)
    else $error("data ready high while empty");
  a_clear_flags: assert property
    (master_clear_pin |=> rx_fifo_empty_flag && !data_ready && !rx_fifo_full_flag)
    else $error("master clear left flags set");
  a_empty_levels: assert property (rx_fifo_empty_flag |-> !rx_fifo_half_flag && !rx_fifo_full_flag)
    else $error("fill flags high while empty");
  a_flag_pin_map: assert property
    (rx_flag_pin == (rx_flag_select_full ? rx_fifo_full_flag : rx_fifo_empty_flag))
    else $error("flag pin disagrees with selected flag");
endmodule
bind awr_receiver awr_rx_checker chk_u (.sys_clk, .rst_n, .clk_en, .master_clear_pin, .rx_flag_select_full,
  .host_cmd_valid, .host_opcode, .host_rsp_valid, .host_word, .end_of_word_strobe, .data_ready,
  .rx_fifo_empty_flag, .rx_fifo_half_flag, .rx_fifo_full_flag, .rx_flag_pin);
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench of the ARINC word receiver
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk, rst_n, clk_en, master_clear_pin, low_speed, label_order_select, label_filter_enable;
  logic decode_match_enable, match_value_bit10, match_value_bit9, rx_parity_check_enable;
  logic rx_flag_select_full, host_cmd_valid, host_rsp_valid, end_of_word_strobe, data_ready;
  logic rx_fifo_empty_flag, rx_fifo_half_flag, rx_fifo_full_flag, rx_flag_pin;
  logic [1:0] line_level;
  logic [7:0] host_opcode;
  logic [31:0] host_word, aw;
  logic [255:0] host_label_data, host_label_table;
  int err_total, checks, cycles;
  awr_receiver dut_u (.sys_clk, .rst_n, .clk_en, .master_clear_pin, .line_level, .low_speed,
    .label_order_select, .label_filter_enable, .decode_match_enable, .match_value_bit10, .match_value_bit9,
    .rx_parity_check_enable, .rx_flag_select_full, .host_cmd_valid, .host_opcode, .host_label_data,
    .host_rsp_valid, .host_word, .host_label_table, .end_of_word_strobe, .data_ready,
    .rx_fifo_empty_flag, .rx_fifo_half_flag, .rx_fifo_full_flag, .rx_flag_pin);
  awr_line_model line_u (.sys_clk, .line_level);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 100000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    @(negedge sys_clk);
    host_opcode = op;
    host_cmd_valid = 1'b1;
    @(negedge sys_clk);
    host_cmd_valid = 1'b0;
    chk("response", 256'(host_rsp_valid), 256'(op == 8'h08 || op == 8'h0D));
  endtask
  function automatic logic [31:0] exp_word(input logic [31:0] w, input logic ord, input logic par);
    logic [31:0] r;
    r = w;
    for (int i = 0; i < 8; i++) begin
      if (!ord) r[7-i] = w[i];
    end
    if (par) r[31] = ~^w;
    return r;
  endfunction
  // One random word under the given filter, order and parity settings
  task automatic word_case(input logic ord, par, filt, dec, flip, keep, rd);
    @(negedge sys_clk);
    aw = $urandom;
    label_order_select = ord;
    rx_parity_check_enable = par;
    label_filter_enable = filt;
    decode_match_enable = dec;
    match_value_bit10 = aw[9] ^ flip;
    match_value_bit9 = aw[8];
    rx_flag_select_full = 1'($urandom);
    line_u.send_word(aw, 10, 32);
    chk("empty", 256'(rx_fifo_empty_flag), 256'(!keep));
    chk("ready", 256'(data_ready), 256'(keep));
    chk("flag pin", 256'(rx_flag_pin), 256'(!rx_flag_select_full && !keep));
    if (keep && rd) begin
      cmd(awr_pkg::OP_READ_WORD);
      chk("word", 256'(host_word), 256'(exp_word(aw, ord, par)));
      chk("drained", 256'(rx_fifo_empty_flag), 256'h1);
    end
  endtask
  initial begin
    void'($urandom(48));
    {rst_n, master_clear_pin, low_speed, label_order_select, label_filter_enable} = 5'h0;
    {decode_match_enable, match_value_bit10, match_value_bit9, rx_parity_check_enable} = 4'h0;
    {rx_flag_select_full, host_cmd_valid, host_opcode} = 10'h0;
    clk_en = 1'b1;
    host_label_data = 256'h0;
    err_total = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("empty at start", 256'(rx_fifo_empty_flag), 256'h1);
    cmd(awr_pkg::OP_READ_WORD);
    chk("empty read", 256'(host_word), 256'h0);
    for (int i = 0; i < 8; i++) begin
      host_label_data[i*32 +: 32] = $urandom;
    end
    cmd(awr_pkg::OP_LABEL_WRITE);
    cmd(awr_pkg::OP_READ_LABELS);
    chk("table load", host_label_table, host_label_data);
    cmd(awr_pkg::OP_LABEL_NONE);
    cmd(awr_pkg::OP_READ_LABELS);
    chk("table none", host_label_table, 256'h0);
    word_case(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    word_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    cmd(awr_pkg::OP_LABEL_ALL);
    word_case(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    word_case(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    line_u.send_word($urandom, 14, 4);
    chk("late bits", 256'(rx_fifo_empty_flag), 256'h1);
    word_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    @(negedge sys_clk);
    master_clear_pin = 1'b1;
    @(negedge sys_clk);
    master_clear_pin = 1'b0;
    chk("clear empty", 256'(rx_fifo_empty_flag), 256'h1);
    chk("clear ready", 256'(data_ready), 256'h0);
    cmd(awr_pkg::OP_READ_LABELS);
    chk("table kept", host_label_table, {8{32'hFFFFFFFF}});
    cmd(awr_pkg::OP_READ_WORD);
    chk("clear read", 256'(host_word), 256'h0);
    stop_test();
  end
endmodule
`default_nettype wire
